// ### pmc_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
// Functional notes
// - After reset the device runs in run mode on the undivided clock.
// - Slow select divides CPU and peripheral clock by 32; clearing restores.
// - Wait while slow gives slow-wait, peripherals keep the divided clock.
// - Lite timer ticks at oscillator divided by 32 in every mode but plain halt.
// - Wait instruction stops CPU, peripherals keep running, state kept.
// - Entering wait clears the global interrupt mask.
// - Wait lasts until interrupt or reset, then vector fetch follows.
// - Servicing a wake interrupt pushes flags, sets mask, pop clears it.
// - Halt picks active-halt from timebase enable or timer overflow setup.
// - Active-halt wakes only on reset or lite/autoreload timer interrupts.
// - Reset ending active-halt waits 256 cycles before reset fetch.
// - Interrupt ending active-halt resumes at once, no delay.
// - Entering active-halt clears the mask; pending interrupt wakes at once.
// - Active-halt keeps only oscillator, lite timer and timer clock running, whichever timer is selected.
// - Active-halt with watchdog stop option clear gives no watchdog reset.
// - Plain halt stops the oscillator and all peripheral clocks.
// - Leaving plain halt restarts oscillator and waits 256 cycles.
// - Entering plain halt forces the interrupt mask to zero.
// - Halt with watchdog running may give a watchdog reset instead.
// - With PLL enabled, the 256-cycle wake delay is followed by the PLL start-up delay.
// - Byte 8E decodes as the halt instruction.
module pmc_controller
    import pmc_pkg::*;
#(
    parameter int STAB_CYCLES = `PMC_STAB_CYCLES,
    parameter int PLL_STARTUP = `PMC_PLL_STARTUP
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic slow_mode_select,
    input wire logic wait_instruction,
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic timebase_irq_enable,
    input wire logic overflow_irq_enable,
    input wire logic autoreload_clk_sel,
    input wire logic counter_clock_sel0,
    input wire logic watchdog_enabled,
    input wire logic watchdog_stop_option,
    input wire logic pll_enabled,
    input wire logic wake_reset,
    input wire logic irq_any,
    input wire logic irq_halt_capable,
    input wire logic irq_lite_timer,
    input wire logic irq_autoreload_timer,
    input wire logic irq_vector_fetch,
    input wire logic flags_pop,
    input wire logic popped_mask,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic lite_timer_tick,
    output logic timer_clk_en,
    output logic osc_enable,
    output logic interrupt_mask,
    output logic flags_push,
    output logic watchdog_reset,
    output logic reset_fetch,
    output logic [2:0] power_mode
);
    localparam int STW = $clog2(STAB_CYCLES + 1);
    localparam int PLW = $clog2(PLL_STARTUP + 1);
    // Zero delays would make the end-count compares underflow
    if (STAB_CYCLES < 1 || PLL_STARTUP < 1) begin : g_bad_delay
        $error("delay counts must be at least one");
    end

    pmc_state_type state;
    pmc_div_if div_link ();
    logic active_sel;
    logic wake_by_reset;
    logic [STW-1:0] stab_count;
    logic [PLW-1:0] pll_count;
    logic slow_tick;
    logic halt_exec;
    logic active_cond;
    logic wait_wake;
    logic ahalt_wake;
    logic halt_wake;
    logic wdg_trip;

    assign div_link.run = 1'b1;
    assign slow_tick = div_link.tick;

    // One shared divider feeds both slow mode and the lite timer
    pmc_divider #(.DIV(`PMC_SLOW_DIV)) u_div (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .link(div_link)
    );

    assign halt_exec = opcode_valid && (opcode == `PMC_HALT_OPCODE) && (state == pmc_run);
    assign active_cond = timebase_irq_enable ||
        (overflow_irq_enable && !autoreload_clk_sel && counter_clock_sel0);
    // watchdog reset only with the stop option set
    assign wdg_trip = halt_exec && watchdog_enabled && watchdog_stop_option;
    assign wait_wake = irq_any;
    assign ahalt_wake = irq_lite_timer || irq_autoreload_timer;
    assign halt_wake = irq_halt_capable;

    // Mode sequencing; reset pin is the wake reset from low-power states
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= pmc_run;
        end else if (clk_en) begin
            unique case (state)
                pmc_run: begin
                    if (wdg_trip) begin
                        state <= pmc_run;
                    end else if (halt_exec) begin
                        state <= active_cond ? pmc_active_halt : pmc_halt;
                    end else if (wait_instruction) begin
                        state <= pmc_wait;
                    end
                end
                pmc_wait: begin
                    if (wake_reset || wait_wake) begin
                        state <= pmc_run;
                    end
                end
                pmc_active_halt: begin
                    // reset takes the delay, interrupt does not
                    if (wake_reset) begin
                        state <= pmc_stab;
                    end else if (ahalt_wake) begin
                        state <= pmc_run;
                    end
                end
                pmc_halt: begin
                    if (wake_reset || halt_wake) begin
                        state <= pmc_stab;
                    end
                end
                pmc_stab: begin
                    if (stab_count == STW'(STAB_CYCLES - 1)) begin
                        state <= pll_enabled ? pmc_pll_wait : pmc_run;
                    end
                end
                pmc_pll_wait: begin
                    if (pll_count == PLW'(PLL_STARTUP - 1)) begin
                        state <= pmc_run;
                    end
                end
                default: begin
                    state <= pmc_run;
                end
            endcase
        end
    end

    // flavour and wake cause held through the sleep
    always_ff @(posedge clk) begin
        if (reset) begin
            active_sel <= 1'b0;
            wake_by_reset <= 1'b0;
        end else if (clk_en) begin
            if (halt_exec) begin
                active_sel <= active_cond;
            end
            if ((state == pmc_active_halt || state == pmc_halt) && wake_reset) begin
                wake_by_reset <= 1'b1;
            end else if (state == pmc_halt && halt_wake) begin
                wake_by_reset <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stab_count <= '0;
        end else if (clk_en) begin
            if (state == pmc_stab) begin
                stab_count <= stab_count + 1'b1;
            end else begin
                stab_count <= '0;
            end
        end
    end

    // PLL lock wait counter
    always_ff @(posedge clk) begin
        if (reset) begin
            pll_count <= '0;
        end else if (clk_en) begin
            if (state == pmc_pll_wait) begin
                pll_count <= pll_count + 1'b1;
            end else begin
                pll_count <= '0;
            end
        end
    end

    // Interrupt mask: cleared at sleep entry, set on vector, restored on pop
    always_ff @(posedge clk) begin
        if (reset) begin
            interrupt_mask <= 1'b1;
            flags_push <= 1'b0;
        end else if (clk_en) begin
            flags_push <= irq_vector_fetch;
            if (irq_vector_fetch) begin
                interrupt_mask <= 1'b1;
            end else if (state == pmc_run && (halt_exec || wait_instruction) && !wdg_trip) begin
                interrupt_mask <= 1'b0;
            end else if (flags_pop) begin
                interrupt_mask <= popped_mask;
            end
        end
    end

    // Clock gating; slow select only matters where CPU or peripherals run
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            lite_timer_tick <= 1'b0;
            timer_clk_en <= 1'b0;
            osc_enable <= 1'b1;
        end else if (clk_en) begin
            // slow division for CPU and peripherals
            cpu_clk_en <= (state == pmc_run) && (!slow_mode_select || slow_tick);
            periph_clk_en <= (state == pmc_run || state == pmc_wait) &&
                (!slow_mode_select || slow_tick);
            // lite timer ignores slow and runs in active-halt
            lite_timer_tick <= slow_tick && state != pmc_halt;
            timer_clk_en <= state != pmc_halt;
            osc_enable <= state != pmc_halt;
        end
    end

    // Watchdog reset and reset fetch strobes
    always_ff @(posedge clk) begin
        if (reset) begin
            watchdog_reset <= 1'b0;
            reset_fetch <= 1'b0;
        end else if (clk_en) begin
            watchdog_reset <= wdg_trip;
            reset_fetch <= (state == pmc_wait && wake_reset) ||
                (state == pmc_stab && wake_by_reset && !pll_enabled &&
                 stab_count == STW'(STAB_CYCLES - 1)) ||
                (state == pmc_pll_wait && wake_by_reset && pll_count == PLW'(PLL_STARTUP - 1));
        end
    end

    // Mode code seen by software
    always_ff @(posedge clk) begin
        if (reset) begin
            power_mode <= 3'h0;
        end else if (clk_en) begin
            power_mode <= state;
        end
    end

    // no watchdog reset when active-halt chosen with option clear
    no_wdg_trip_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && halt_exec && !watchdog_stop_option) |=> !watchdog_reset)
        else $error("watchdog reset with stop option clear");
    wdg_reset_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && halt_exec && watchdog_enabled && watchdog_stop_option) |=> watchdog_reset)
        else $error("missing watchdog reset");
    // flavour, judged on the enables as they stood at the halt
    halt_flavour_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && halt_exec && !wdg_trip) |=>
        (state == ($past(active_cond) ? pmc_active_halt : pmc_halt)))
        else $error("wrong halt flavour");
    // latched flavour agrees with the sleep state
    flavour_hold_a: assert property (@(posedge clk) disable iff (reset)
        (state == pmc_active_halt || state == pmc_halt) |->
        (active_sel == (state == pmc_active_halt)))
        else $error("halt flavour not held");
    osc_off_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_halt && $past(state) == pmc_halt) |-> !osc_enable)
        else $error("oscillator running in halt");
    fast_wake_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_active_halt && !wake_reset && ahalt_wake) |=> state == pmc_run)
        else $error("active-halt interrupt wake delayed");
    ahalt_refuse_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_active_halt && !wake_reset && !ahalt_wake) |=>
        state == pmc_active_halt)
        else $error("active-halt left without a wake source");
    stab_len_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && $rose(state == pmc_stab)) |-> stab_count == '0)
        else $error("stabilisation count not cleared");
    // plain halt wake always goes through the delay
    halt_stab_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_halt && (wake_reset || halt_wake)) |=> state == pmc_stab)
        else $error("plain halt wake skipped the delay");
    wait_mask_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_run && wait_instruction && !halt_exec && !irq_vector_fetch)
        |=> !interrupt_mask)
        else $error("mask not cleared on wait");
    // mask cleared on halt entry unless a vector wins
    halt_mask_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && halt_exec && !wdg_trip && !irq_vector_fetch) |=> !interrupt_mask)
        else $error("mask not cleared on halt");
    vec_mask_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && irq_vector_fetch) |=> (interrupt_mask && flags_push))
        else $error("mask not set on service");
    wait_cpu_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_wait) |=> !cpu_clk_en)
        else $error("CPU clocked in wait");
    // slow mode gates both enables between divider ticks
    slow_gate_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && slow_mode_select && !slow_tick) |=> (!cpu_clk_en && !periph_clk_en))
        else $error("clock enable outside slow tick");
    // lite timer ticks whatever the slow setting
    lt_tick_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && slow_tick && state == pmc_run) |=> lite_timer_tick)
        else $error("lite timer tick missing");
    // active-halt keeps only oscillator and timer
    ahalt_clocks_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_active_halt) |=>
        (osc_enable && timer_clk_en && !cpu_clk_en && !periph_clk_en))
        else $error("wrong clocks in active-halt");
    // reset wake from wait fetches the reset vector
    wait_fetch_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == pmc_wait && wake_reset) |=> reset_fetch)
        else $error("no reset fetch after wait");

    cov_wait_c: cover property (@(posedge clk) state == pmc_wait ##1 state == pmc_run);
    cov_ahalt_c: cover property (@(posedge clk) state == pmc_active_halt ##1 state == pmc_run);
    cov_halt_c: cover property (@(posedge clk) state == pmc_halt ##1 state == pmc_stab);
    cov_pll_c: cover property (@(posedge clk) state == pmc_pll_wait);
    cov_wdg_c: cover property (@(posedge clk) watchdog_reset);
endmodule : pmc_controller
`default_nettype wire

// ### pmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the CPU core: takes a vector when unmasked, returns after a routine
module pmc_cpu_model #(
    parameter int ROUTINE = 6
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic svc_req,
    input wire logic cpu_clk_en,
    input wire logic interrupt_mask,
    output logic irq_vector_fetch,
    output logic flags_pop,
    output logic popped_mask
);
    int left;
    logic take;
    // Vector taken only while the CPU is clocked and unmasked
    assign take = (left == 0) && svc_req && cpu_clk_en && !interrupt_mask;
    always @(posedge clk) begin
        if (reset) begin
            irq_vector_fetch <= 1'b0;
            flags_pop <= 1'b0;
            left <= 0;
        end else begin
            irq_vector_fetch <= take;
            flags_pop <= (left == 1);
            if (take) begin
                left <= ROUTINE;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
    // Stacked mask was clear; off the pop the line shows the inverse, never a stale value
    assign popped_mask = ~flags_pop;
endmodule : pmc_cpu_model
`default_nettype wire

// ### pmc_defs.svh
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Clock division for slow mode and for the lite timer
`define PMC_SLOW_DIV 32
`define PMC_SLOW_DIV_W 5
// Stabilisation delay after wake from halt, in CPU cycles
`define PMC_STAB_CYCLES 256
`define PMC_STAB_W 9
// Halt opcode
`define PMC_HALT_OPCODE 8'h8E
// Default PLL start-up delay in cycles
`define PMC_PLL_STARTUP 64
`endif

// ### pmc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between the controller and its divider
interface pmc_div_if;
    logic run;
    logic tick;
    modport ctrl (output run, input tick);
    modport div (input run, output tick);
endinterface : pmc_div_if
`default_nettype wire

// ### pmc_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_divider #(
    parameter int DIV = `PMC_SLOW_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    pmc_div_if.div link
);
    localparam int W = $clog2(DIV);
    // A divide by one would leave the counter with no bits
    if (DIV < 2) begin : g_bad_div
        $error("divider must be at least 2");
    end
    logic [W-1:0] count;
    // Free counter, one tick every DIV cycles while running
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
        end else if (clk_en) begin
            if (!link.run || count == W'(DIV - 1)) begin
                count <= '0;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
    assign link.tick = link.run && (count == W'(DIV - 1));
endmodule : pmc_divider
`default_nettype wire

// ### pmc_pkg.sv
package pmc_pkg;
    // Power mode states
    typedef enum logic [2:0] {
        pmc_run = 3'b000,
        pmc_wait = 3'b001,
        pmc_active_halt = 3'b010,
        pmc_halt = 3'b011,
        pmc_stab = 3'b100,
        pmc_pll_wait = 3'b101
    } pmc_state_type;
endpackage : pmc_pkg

// ### power_mode_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
    import pmc_pkg::*;
    localparam int STAB = 4;
    localparam int PLL = 2;
    typedef struct {logic [3:0] flav; logic [2:0] mode;} pmc_row_type;
    // Flavour bits: {timebase, overflow, autoreload clock select, counter clock 0}
    pmc_row_type rows [6] = '{'{4'h8, 3'h2}, '{4'h5, 3'h2}, '{4'hF, 3'h2},
        '{4'h0, 3'h3}, '{4'h7, 3'h3}, '{4'h4, 3'h3}};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic slow_mode_select = 1'b0;
    logic wait_instruction = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic opcode_valid = 1'b0;
    logic [3:0] flav = 4'h0;
    logic wd_en = 1'b0;
    logic watchdog_stop_option = 1'b0;
    logic pll_en = 1'b0;
    logic wake_reset = 1'b0;
    logic [3:0] irq = 4'h0; // {autoreload, lite, halt capable, any}
    logic svc_req = 1'b0;
    logic fetch, pop, pmask, cpu_en, per_en, lt_tick, tmr_en, osc_en, mask, push, wdr, rfetch;
    logic [2:0] power_mode;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_cpu = 0, n_per = 0, n_lt = 0, n_wdr = 0, n_push = 0, n_rf = 0;
    int t, a, b, c;

    pmc_controller #(.STAB_CYCLES(STAB), .PLL_STARTUP(PLL)) DUT (
        .clk(clk), .reset(reset), .clk_en(1'b1), .slow_mode_select(slow_mode_select),
        .wait_instruction(wait_instruction), .opcode(opcode), .opcode_valid(opcode_valid),
        .timebase_irq_enable(flav[3]), .overflow_irq_enable(flav[2]),
        .autoreload_clk_sel(flav[1]), .counter_clock_sel0(flav[0]), .watchdog_enabled(wd_en),
        .watchdog_stop_option(watchdog_stop_option), .pll_enabled(pll_en),
        .wake_reset(wake_reset), .irq_any(irq[0]), .irq_halt_capable(irq[1]),
        .irq_lite_timer(irq[2]), .irq_autoreload_timer(irq[3]), .irq_vector_fetch(fetch),
        .flags_pop(pop), .popped_mask(pmask), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .lite_timer_tick(lt_tick), .timer_clk_en(tmr_en), .osc_enable(osc_en),
        .interrupt_mask(mask), .flags_push(push), .watchdog_reset(wdr),
        .reset_fetch(rfetch), .power_mode(power_mode));
    pmc_cpu_model #(.ROUTINE(6)) cpu (.clk(clk), .reset(reset), .svc_req(svc_req),
        .cpu_clk_en(cpu_en), .interrupt_mask(mask), .irq_vector_fetch(fetch),
        .flags_pop(pop), .popped_mask(pmask));

    always #2 clk = ~clk;

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Bounded wait for a mode code; k returns the cycles spent
    task automatic wait_mode(input logic [2:0] m, input int lim, output int k);
        k = 0;
        while (power_mode !== m && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_mode
    // One instruction byte, optionally with the wait instruction in the same cycle
    task automatic exec(input logic [7:0] op, input logic w);
        opcode = op;
        opcode_valid = 1'b1;
        wait_instruction = w;
        cyc(1);
        opcode_valid = 1'b0;
        wait_instruction = 1'b0;
    endtask : exec
    task automatic tally(input int n, output int cc, output int cp, output int cl);
        cc = n_cpu;
        cp = n_per;
        cl = n_lt;
        cyc(n);
        cc = n_cpu - cc;
        cp = n_per - cp;
        cl = n_lt - cl;
    endtask : tally

    // Pulse tallies and the run ceiling; the test reads differences only
    always @(posedge clk) begin
        cycles <= cycles + 1;
        n_cpu <= n_cpu + int'(cpu_en);
        n_per <= n_per + int'(per_en);
        n_lt <= n_lt + int'(lt_tick);
        n_wdr <= n_wdr + int'(wdr);
        n_push <= n_push + int'(push);
        n_rf <= n_rf + int'(rfetch);
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        cyc(6);
        reset = 1'b0;
        cyc(3);
        chk(8'(power_mode), 8'h00);
        chk(8'({mask, osc_en}), 8'h03);
        wd_en = 1'b1;
        a = n_wdr;
        foreach (rows[i]) begin
            // Fresh reset so the entry clear of the mask is seen each time
            reset = 1'b1;
            cyc(1);
            reset = 1'b0;
            flav = rows[i].flav;
            exec(8'h8E, 1'b0);
            wait_mode(rows[i].mode, 6, t);
            chk(8'(power_mode), 8'(rows[i].mode));
            chk(8'(mask), 8'h00);
            chk(8'({osc_en, tmr_en}), rows[i].mode == 3'h2 ? 8'h03 : 8'h00);
            chk(8'({cpu_en, per_en}), 8'h00);
            b = n_rf;
            wake_reset = 1'b1;
            wait_mode(3'h0, 40, t);
            wake_reset = 1'b0;
            cyc(2);
            chk(8'(t >= STAB), 8'h01);
            chk(8'(n_rf - b), 8'h01);
        end
        chk(8'(n_wdr - a), 8'h00);
        watchdog_stop_option = 1'b1;
        flav = 4'h0;
        exec(8'h8E, 1'b0);
        cyc(4);
        chk(8'(n_wdr - a), 8'h01);
        chk(8'(power_mode), 8'h00);
        watchdog_stop_option = 1'b0;
        wd_en = 1'b0;
        flav = 4'h8;
        exec(8'h8F, 1'b0);
        cyc(4);
        chk(8'(power_mode), 8'h00);
        for (int k = 0; k < 2; k++) begin
            flav = 4'h8;
            exec(8'h8E, 1'b0);
            wait_mode(3'h2, 6, t);
            flav = 4'h0;
            irq = 4'h3;
            cyc(8);
            chk(8'(power_mode), 8'h02);
            chk(8'(osc_en), 8'h01);
            irq = k ? 4'h8 : 4'h4;
            wait_mode(3'h0, 8, t);
            irq = 4'h0;
            chk(8'(t <= 3), 8'h01);
        end
        for (int k = 0; k < 2; k++) begin
            pll_en = k[0];
            exec(8'h8E, 1'b1);
            wait_mode(3'h3, 6, t);
            chk(8'(power_mode), 8'h03);
            b = n_rf;
            irq = 4'h2;
            wait_mode(3'h0, 40, t);
            irq = 4'h0;
            chk(8'(n_rf - b), 8'h00);
            chk(8'(t >= (k ? STAB + PLL : STAB)), 8'h01);
        end
        tally(64, a, b, c);
        chk(8'(a), 8'h40);
        chk(8'(c), 8'h02);
        slow_mode_select = 1'b1;
        cyc(40);
        tally(64, a, b, c);
        chk(8'({a[3:0], c[3:0]}), 8'h22);
        // Reset sets the mask again, so the wait entry clear is visible
        reset = 1'b1;
        cyc(1);
        reset = 1'b0;
        wait_instruction = 1'b1;
        cyc(1);
        wait_instruction = 1'b0;
        wait_mode(3'h1, 6, t);
        chk(8'(mask), 8'h00);
        tally(64, a, b, c);
        chk(8'({a[3:0], b[3:0]}), 8'h02);
        chk(8'(c), 8'h02);
        irq = 4'h1;
        wait_mode(3'h0, 8, t);
        irq = 4'h0;
        chk(8'(power_mode), 8'h00);
        slow_mode_select = 1'b0;
        a = n_push;
        svc_req = 1'b1;
        for (int k = 0; k < 20 && n_push == a; k++) cyc(1);
        svc_req = 1'b0;
        // push sets mask, pop clears it
        chk(8'({n_push - a, mask}), 8'h03);
        for (int k = 0; k < 20 && mask !== 1'b0; k++) cyc(1);
        chk(8'(mask), 8'h00);
        exec(8'h00, 1'b1);
        cyc(3);
        // reset wake from wait pulses the reset fetch
        b = n_rf;
        wake_reset = 1'b1;
        cyc(1);
        wake_reset = 1'b0;
        cyc(2);
        chk(8'(n_rf - b), 8'h01);
        exec(8'h00, 1'b1);
        cyc(3);
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(3);
        chk(8'({power_mode, mask, osc_en}), 8'h03);
        report_and_stop();
    end
endmodule : power_mode_controller_test
`default_nettype wire
